// [common/iibs_pkg.sv]
// shared constants and types for the indexed/inherent bus cycle sequencer
package iibs_pkg;
    // address forced onto the bus during dummy reads
    localparam logic [15:0] TOP_ADDR = 16'hFFFF;
    // total bus cycles per instruction class
    localparam logic [3:0] CYC_REG = 4'h2;
    localparam logic [3:0] CYC_JUMP = 4'h3;
    localparam logic [3:0] CYC_INH3 = 4'h3;
    localparam logic [3:0] CYC_READ = 4'h4;
    localparam logic [3:0] CYC_PULL_ACC = 4'h4;
    localparam logic [3:0] CYC_PUSH_IDX = 4'h4;
    localparam logic [3:0] CYC_WORD = 4'h5;
    localparam logic [3:0] CYC_PULL_IDX = 4'h5;
    localparam logic [3:0] CYC_LONG = 4'h6;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CYC = 4'h0;

    // instruction classes handed in with the start strobe
    typedef enum logic [4:0] {
        CLS_IDX_JUMP = 5'h00, CLS_IDX_READ = 5'h01, CLS_IDX_STORE = 5'h02,
        CLS_IDX_LOAD16 = 5'h03, CLS_IDX_STORE16 = 5'h04, CLS_IDX_RMW = 5'h05,
        CLS_IDX_TEST = 5'h06, CLS_IDX_ARITH16 = 5'h07, CLS_IDX_CALL = 5'h08,
        CLS_INH_REG = 5'h09, CLS_INH_TOP3 = 5'h0A, CLS_INH_SP_INC = 5'h0B,
        CLS_INH_SP_DEC = 5'h0C, CLS_INH_STACK_TO_INDEX = 5'h0D,
        CLS_INH_PUSH_ACC = 5'h0E, CLS_INH_PULL_ACC = 5'h0F,
        CLS_INH_PUSH_INDEX = 5'h10, CLS_INH_PULL_INDEX = 5'h11,
        CLS_EXT_RMW = 5'h12, CLS_EXT_TEST = 5'h13
    } iibs_class_t;

    // address source of one bus cycle
    typedef enum logic [3:0] {
        SEL_PC = 4'h0, SEL_PC1 = 4'h1, SEL_PC2 = 4'h2, SEL_TOP = 4'h3,
        SEL_EA = 4'h4, SEL_EA1 = 4'h5, SEL_SP = 4'h6, SEL_SPP1 = 4'h7
    } iibs_asel_t;

    // meaning of the data byte in one bus cycle
    typedef enum logic [3:0] {
        KIND_OPCODE = 4'h0, KIND_OFFSET = 4'h1, KIND_RESTART_LO = 4'h2,
        KIND_OPERAND = 4'h3, KIND_OPERAND_HI = 4'h4, KIND_OPERAND_LO = 4'h5,
        KIND_NEW_OPERAND = 4'h6, KIND_IGNORED = 4'h7, KIND_NEXT_OPCODE = 4'h8,
        KIND_RET_LO = 4'h9, KIND_RET_HI = 4'hA, KIND_ACC = 4'hB,
        KIND_INDEX_LO = 4'hC, KIND_INDEX_HI = 4'hD, KIND_ADDR_HI = 4'hE,
        KIND_ADDR_LO = 4'hF
    } iibs_kind_t;

    // sequencer state, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } iibs_state_t;
endpackage : iibs_pkg

// [rtl/iibs_seq.sv]
// bus cycle sequencer for indexed and inherent instructions
`timescale 1ns/1ps
module iibs_seq (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [4:0] class_in,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] index_in,
    input wire logic [15:0] sp_in,
    input wire logic [7:0] acc_in,
    input wire logic [15:0] word_in,
    input wire logic [7:0] new_operand_in,
    input wire logic [7:0] data_in,
    output logic [15:0] addr_out,
    output logic rw_out,
    output logic data_oe_out,
    output logic [7:0] data_out,
    output logic bus_cycle_out,
    output logic [3:0] cycle_out,
    output logic [3:0] kind_out,
    output logic busy_out,
    output logic done_out,
    output logic [15:0] sp_out
);
    // control state
    iibs_pkg::iibs_state_t state_r; // idle or presenting cycles
    iibs_pkg::iibs_class_t cls_r; // class of the running instruction
    iibs_pkg::iibs_asel_t asel_r; // address source of the cycle on the bus
    logic [3:0] cur_r; // cycle number now on the bus
    logic [3:0] tot_r; // total cycles of the running instruction
    logic [15:0] pc_r; // opcode address
    logic [15:0] ix_r; // index register copy
    logic [15:0] sp_r; // stack pointer, tracks pushes and pulls
    logic [7:0] off_r; // offset, or extended low address byte
    logic [7:0] ahi_r; // extended high address byte

    // start is taken when idle or on the last cycle, so instructions chain
    wire last_w = (state_r == iibs_pkg::ST_RUN) && (cur_r == tot_r);
    wire accept_w = start_in && ((state_r == iibs_pkg::ST_IDLE) || last_w);
    wire advance_w = (state_r == iibs_pkg::ST_RUN) && !last_w;
    wire present_w = accept_w || advance_w;
    wire [3:0] ncyc_w = accept_w ? 4'h1 : cur_r + 4'h1;
    wire iibs_pkg::iibs_class_t cls_w = accept_w ? iibs_pkg::iibs_class_t'(class_in) : cls_r;
    wire [15:0] pc_w = accept_w ? pc_in : pc_r;
    wire is_ext_w = (cls_r == iibs_pkg::CLS_EXT_RMW) || (cls_r == iibs_pkg::CLS_EXT_TEST);
    // extended low byte is still on data_in at the edge that launches cycle four
    wire [7:0] lo_w = (is_ext_w && cur_r == 4'h3) ? data_in : off_r;
    // offset is unsigned and zero-extended onto the index
    wire [15:0] ea_w = is_ext_w ? {ahi_r, lo_w} : ix_r + {8'h00, off_r};
    wire [15:0] ret_w = pc_r + 16'h0002;

    // total cycle count per class
    logic [3:0] tot_w;
    always_comb begin
        case (cls_w)
            iibs_pkg::CLS_INH_REG: tot_w = iibs_pkg::CYC_REG;
            iibs_pkg::CLS_IDX_JUMP: tot_w = iibs_pkg::CYC_JUMP;
            iibs_pkg::CLS_INH_TOP3, iibs_pkg::CLS_INH_SP_INC, iibs_pkg::CLS_INH_SP_DEC,
            iibs_pkg::CLS_INH_STACK_TO_INDEX, iibs_pkg::CLS_INH_PUSH_ACC:
                tot_w = iibs_pkg::CYC_INH3;
            iibs_pkg::CLS_IDX_READ, iibs_pkg::CLS_IDX_STORE: tot_w = iibs_pkg::CYC_READ;
            iibs_pkg::CLS_INH_PULL_ACC: tot_w = iibs_pkg::CYC_PULL_ACC;
            iibs_pkg::CLS_INH_PUSH_INDEX: tot_w = iibs_pkg::CYC_PUSH_IDX;
            iibs_pkg::CLS_IDX_LOAD16, iibs_pkg::CLS_IDX_STORE16: tot_w = iibs_pkg::CYC_WORD;
            iibs_pkg::CLS_INH_PULL_INDEX: tot_w = iibs_pkg::CYC_PULL_IDX;
            default: tot_w = iibs_pkg::CYC_LONG; // modify, test, word arith, call, extended
        endcase
    end

    // per-cycle address source, direction and data meaning
    iibs_pkg::iibs_asel_t asel_w;
    iibs_pkg::iibs_kind_t kind_w;
    logic rd_w;
    always_comb begin
        asel_w = iibs_pkg::SEL_TOP;
        kind_w = iibs_pkg::KIND_RESTART_LO;
        rd_w = 1'b1;
        if (ncyc_w == 4'h1) begin
            asel_w = iibs_pkg::SEL_PC;
            kind_w = iibs_pkg::KIND_OPCODE;
        end else if (ncyc_w == 4'h2) begin
            asel_w = iibs_pkg::SEL_PC1;
            case (cls_w)
                iibs_pkg::CLS_INH_REG, iibs_pkg::CLS_INH_SP_INC, iibs_pkg::CLS_INH_SP_DEC,
                iibs_pkg::CLS_INH_STACK_TO_INDEX, iibs_pkg::CLS_INH_PUSH_ACC,
                iibs_pkg::CLS_INH_PULL_ACC: kind_w = iibs_pkg::KIND_NEXT_OPCODE;
                iibs_pkg::CLS_INH_TOP3, iibs_pkg::CLS_INH_PUSH_INDEX,
                iibs_pkg::CLS_INH_PULL_INDEX: kind_w = iibs_pkg::KIND_IGNORED;
                iibs_pkg::CLS_EXT_RMW, iibs_pkg::CLS_EXT_TEST: kind_w = iibs_pkg::KIND_ADDR_HI;
                default: kind_w = iibs_pkg::KIND_OFFSET; // offset byte
            endcase
        end else begin
            case (cls_w)
                iibs_pkg::CLS_IDX_READ, iibs_pkg::CLS_IDX_STORE: begin
                    if (ncyc_w == 4'h4) begin
                        asel_w = iibs_pkg::SEL_EA;
                        kind_w = iibs_pkg::KIND_OPERAND;
                        rd_w = (cls_w == iibs_pkg::CLS_IDX_READ);
                    end
                end
                iibs_pkg::CLS_IDX_LOAD16, iibs_pkg::CLS_IDX_STORE16,
                iibs_pkg::CLS_IDX_ARITH16: begin
                    // high at ea, low at ea+1
                    if (ncyc_w == 4'h4) begin
                        asel_w = iibs_pkg::SEL_EA;
                        kind_w = iibs_pkg::KIND_OPERAND_HI;
                    end else if (ncyc_w == 4'h5) begin
                        asel_w = iibs_pkg::SEL_EA1;
                        kind_w = iibs_pkg::KIND_OPERAND_LO;
                    end
                    // word store writes both bytes, cycle three stays a read
                    if (cls_w == iibs_pkg::CLS_IDX_STORE16 && ncyc_w != 4'h3) begin
                        rd_w = 1'b0;
                    end
                    // cycle six stays the FFFF default
                end
                iibs_pkg::CLS_IDX_RMW, iibs_pkg::CLS_IDX_TEST,
                iibs_pkg::CLS_EXT_RMW, iibs_pkg::CLS_EXT_TEST: begin
                    if (ncyc_w == 4'h3 && is_ext_w) begin
                        asel_w = iibs_pkg::SEL_PC2;
                        kind_w = iibs_pkg::KIND_ADDR_LO;
                    end else if (ncyc_w == 4'h4) begin
                        asel_w = iibs_pkg::SEL_EA;
                        kind_w = iibs_pkg::KIND_OPERAND;
                    end else if (ncyc_w == 4'h6 && (cls_w == iibs_pkg::CLS_IDX_RMW ||
                                                    cls_w == iibs_pkg::CLS_EXT_RMW)) begin
                        // write back new value; test keeps FFFF
                        asel_w = iibs_pkg::SEL_EA;
                        kind_w = iibs_pkg::KIND_NEW_OPERAND;
                        rd_w = 1'b0;
                    end
                end
                iibs_pkg::CLS_IDX_CALL: begin
                    // subroutine opcode, then return address push
                    if (ncyc_w == 4'h4) begin
                        asel_w = iibs_pkg::SEL_EA;
                        kind_w = iibs_pkg::KIND_OPCODE;
                    end else if (ncyc_w != 4'h3) begin
                        asel_w = iibs_pkg::SEL_SP;
                        kind_w = (ncyc_w == 4'h5) ? iibs_pkg::KIND_RET_LO : iibs_pkg::KIND_RET_HI;
                        rd_w = 1'b0;
                    end
                end
                iibs_pkg::CLS_INH_SP_INC, iibs_pkg::CLS_INH_SP_DEC,
                iibs_pkg::CLS_INH_STACK_TO_INDEX: begin
                    asel_w = iibs_pkg::SEL_SP;
                    kind_w = iibs_pkg::KIND_IGNORED;
                end
                iibs_pkg::CLS_INH_PUSH_ACC: begin
                    asel_w = iibs_pkg::SEL_SP;
                    kind_w = iibs_pkg::KIND_ACC;
                    rd_w = 1'b0;
                end
                iibs_pkg::CLS_INH_PUSH_INDEX: begin
                    asel_w = iibs_pkg::SEL_SP;
                    kind_w = (ncyc_w == 4'h3) ? iibs_pkg::KIND_INDEX_LO
                                              : iibs_pkg::KIND_INDEX_HI;
                    rd_w = 1'b0;
                end
                iibs_pkg::CLS_INH_PULL_ACC, iibs_pkg::CLS_INH_PULL_INDEX: begin
                    // dummy at SP, then reads above it
                    if (ncyc_w == 4'h3) begin
                        asel_w = iibs_pkg::SEL_SP;
                        kind_w = iibs_pkg::KIND_IGNORED;
                    end else begin
                        asel_w = iibs_pkg::SEL_SPP1;
                        // high byte from the lower address
                        if (cls_w == iibs_pkg::CLS_INH_PULL_ACC) begin
                            kind_w = iibs_pkg::KIND_OPERAND;
                        end else begin
                            kind_w = (ncyc_w == 4'h4) ? iibs_pkg::KIND_INDEX_HI
                                                      : iibs_pkg::KIND_INDEX_LO;
                        end
                    end
                end
                // jump and index/double inherents end at FFFF
                default: begin
                    asel_w = iibs_pkg::SEL_TOP;
                    kind_w = iibs_pkg::KIND_RESTART_LO;
                end
            endcase
        end
    end

    // stack pointer step after a stack byte
    wire cur_sp_w = (state_r == iibs_pkg::ST_RUN) && (asel_r == iibs_pkg::SEL_SP);
    wire sp_push_w = cur_sp_w && !rw_out;
    wire sp_pull_w = (state_r == iibs_pkg::ST_RUN) && (asel_r == iibs_pkg::SEL_SPP1);
    // adjust only after the read of the previous value
    wire sp_inc_w = cur_sp_w && (cls_r == iibs_pkg::CLS_INH_SP_INC);
    wire sp_dec_w = cur_sp_w && (cls_r == iibs_pkg::CLS_INH_SP_DEC);
    wire [15:0] sp_nxt = accept_w ? sp_in :
                         (sp_push_w || sp_dec_w) ? sp_r - 16'h0001 :
                         (sp_pull_w || sp_inc_w) ? sp_r + 16'h0001 : sp_r;

    // address mux; stack cycles use the stepped pointer, so back-to-back bytes move on
    logic [15:0] addr_w;
    always_comb begin
        case (asel_w)
            iibs_pkg::SEL_PC: addr_w = pc_w;
            iibs_pkg::SEL_PC1: addr_w = pc_r + 16'h0001;
            iibs_pkg::SEL_PC2: addr_w = pc_r + 16'h0002;
            iibs_pkg::SEL_EA: addr_w = ea_w;
            iibs_pkg::SEL_EA1: addr_w = ea_w + 16'h0001;
            iibs_pkg::SEL_SP: addr_w = sp_nxt;
            iibs_pkg::SEL_SPP1: addr_w = sp_nxt + 16'h0001;
            default: addr_w = iibs_pkg::TOP_ADDR;
        endcase
    end

    // write data mux; inputs are sampled as the cycle is launched
    logic [7:0] wdata_w;
    always_comb begin
        case (kind_w)
            iibs_pkg::KIND_ACC, iibs_pkg::KIND_OPERAND: wdata_w = acc_in;
            iibs_pkg::KIND_OPERAND_HI: wdata_w = word_in[15:8];
            iibs_pkg::KIND_OPERAND_LO: wdata_w = word_in[7:0];
            iibs_pkg::KIND_NEW_OPERAND: wdata_w = new_operand_in;
            iibs_pkg::KIND_RET_LO: wdata_w = ret_w[7:0];
            iibs_pkg::KIND_RET_HI: wdata_w = ret_w[15:8];
            iibs_pkg::KIND_INDEX_LO: wdata_w = ix_r[7:0];
            iibs_pkg::KIND_INDEX_HI: wdata_w = ix_r[15:8];
            default: wdata_w = iibs_pkg::RST_BYTE;
        endcase
    end

    // sequencing and latched operands
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= iibs_pkg::ST_IDLE;
            cls_r <= iibs_pkg::CLS_INH_REG;
            asel_r <= iibs_pkg::SEL_TOP;
            cur_r <= iibs_pkg::RST_CYC;
            tot_r <= iibs_pkg::RST_CYC;
            pc_r <= iibs_pkg::RST_WORD;
            ix_r <= iibs_pkg::RST_WORD;
            sp_r <= iibs_pkg::RST_WORD;
            off_r <= iibs_pkg::RST_BYTE;
            ahi_r <= iibs_pkg::RST_BYTE;
        end else begin
            sp_r <= sp_nxt;
            if (accept_w) begin
                cls_r <= cls_w;
                tot_r <= tot_w;
                pc_r <= pc_in;
                ix_r <= index_in;
            end
            // capture offset (or extended address bytes) from the bus
            if (state_r == iibs_pkg::ST_RUN && cur_r == 4'h2) begin
                if (is_ext_w) begin
                    ahi_r <= data_in;
                end else begin
                    off_r <= data_in;
                end
            end
            if (state_r == iibs_pkg::ST_RUN && cur_r == 4'h3 && is_ext_w) begin
                off_r <= data_in;
            end
            if (present_w) begin
                state_r <= iibs_pkg::ST_RUN;
                cur_r <= ncyc_w;
                asel_r <= asel_w;
            end else begin
                state_r <= iibs_pkg::ST_IDLE;
                cur_r <= iibs_pkg::RST_CYC;
                asel_r <= iibs_pkg::SEL_TOP;
            end
        end
    end

    // registered bus outputs; idle bus reads high with no strobe
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            addr_out <= iibs_pkg::TOP_ADDR;
            rw_out <= 1'b1;
            data_oe_out <= 1'b0;
            data_out <= iibs_pkg::RST_BYTE;
            bus_cycle_out <= 1'b0;
            cycle_out <= iibs_pkg::RST_CYC;
            kind_out <= iibs_pkg::KIND_IGNORED;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            sp_out <= iibs_pkg::RST_WORD;
        end else begin
            addr_out <= present_w ? addr_w : iibs_pkg::TOP_ADDR;
            rw_out <= present_w ? rd_w : 1'b1;
            data_oe_out <= present_w && !rd_w;
            data_out <= (present_w && !rd_w) ? wdata_w : iibs_pkg::RST_BYTE;
            bus_cycle_out <= present_w;
            cycle_out <= present_w ? ncyc_w : iibs_pkg::RST_CYC;
            kind_out <= present_w ? kind_w : iibs_pkg::KIND_IGNORED;
            busy_out <= present_w;
            done_out <= present_w && (ncyc_w == tot_w);
            sp_out <= sp_nxt;
        end
    end
endmodule : iibs_seq

// [dv/iibs_seq_assertions.sv]
// concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
module iibs_seq_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [4:0] class_in,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] sp_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] new_operand_in,
    input wire logic [15:0] addr_out,
    input wire logic rw_out,
    input wire logic data_oe_out,
    input wire logic [7:0] data_out,
    input wire logic [3:0] cycle_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [15:0] sp_out
);
    // a start is only taken when idle or in the last cycle of the previous one
    wire logic go = start_in && (!busy_out || done_out);
    // dummy cycles park the bus on the top address
    wire logic top = addr_out == iibs_pkg::TOP_ADDR;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_first_cycle: assert property (go |=> cycle_out == 4'h1 && addr_out == $past(pc_in))
        else $error("cycle one off opcode address");
    a_second_cycle: assert property (
        cycle_out == 4'h1 |=> cycle_out == 4'h2 && addr_out == $past(addr_out) + 16'h0001)
        else $error("cycle two off next address");
    a_idle_top: assert property (!busy_out |-> top && rw_out && !data_oe_out)
        else $error("idle bus not parked");
    a_jump_three: assert property (
        go && class_in == iibs_pkg::CLS_IDX_JUMP |-> ##3 (top && done_out && cycle_out == 4'h3))
        else $error("jump not three cycles");
    a_read_four: assert property (
        go && class_in == iibs_pkg::CLS_IDX_READ |-> ##4 (done_out && rw_out && cycle_out == 4'h4))
        else $error("byte read not four cycles");
    a_store_write: assert property (
        go && class_in == iibs_pkg::CLS_IDX_STORE |-> ##4 (!rw_out && data_oe_out
        && done_out && data_out == $past(acc_in))) else $error("byte store write wrong");
    a_rmw_write: assert property (
        go && class_in == iibs_pkg::CLS_IDX_RMW |-> ##5 top ##1 (!rw_out && done_out
        && data_out == $past(new_operand_in))) else $error("modify write wrong");
    a_test_nowrite: assert property (
        go && (class_in == iibs_pkg::CLS_IDX_TEST || class_in == iibs_pkg::CLS_EXT_TEST)
        |-> ##6 (top && rw_out && done_out)) else $error("test cycle six not a top read");
    a_push_sp: assert property (
        go && class_in == iibs_pkg::CLS_INH_PUSH_ACC |-> ##3 (!rw_out && addr_out == $past(sp_in, 3))
        ##2 (sp_out == $past(sp_in, 5) - 16'h0001 || $past(go, 2))) else $error("push wrong");
endmodule : iibs_seq_checker
bind iibs_seq iibs_seq_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .start_in(start_in), .class_in(class_in), .pc_in(pc_in), .sp_in(sp_in), .acc_in(acc_in),
    .new_operand_in(new_operand_in), .addr_out(addr_out), .rw_out(rw_out),
    .data_oe_out(data_oe_out), .data_out(data_out), .cycle_out(cycle_out),
    .busy_out(busy_out), .done_out(done_out), .sp_out(sp_out));

// [dv/iibs_mem_model.sv]
// memory and peripherals answering the sequencer's read cycles
`timescale 1ns/1ps
module iibs_mem_model (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic rw_in,
    input wire logic cycle_in,
    output logic [7:0] data_out
);
    // last byte on the lines; inverted while nobody reads so stale data never looks valid
    logic [7:0] last_r = 8'h3C;
    // each cell holds a fixed mix of its address, so the bench can predict every read
    assign data_out = (cycle_in && rw_in) ?
        (addr_in[7:0] ^ {addr_in[11:8], addr_in[15:12]} ^ 8'hA5) : ~last_r;
    always @(posedge clk_in) begin
        last_r <= data_out;
    end
endmodule : iibs_mem_model

// [dv/iibs_seq_tb.sv]
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module iibs_seq_tb;
    // one expected bus cycle: address, read level, write byte
    typedef struct packed {logic [15:0] a; logic rw; logic [7:0] d;} iibs_exp_t;
    localparam logic [15:0] TOP = iibs_pkg::TOP_ADDR;
    // per class, the cycles after the common head, one letter each
    string tail_tab[20] = '{"", "E", "A", "EF", "HL", "ETN", "ETT", "EFT", "Erq", "", "T", "S",
        "S", "S", "a", "SU", "xy", "SUU", "PXTM", "PXTT"};
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start_in = 1'b0;
    logic [4:0] class_in = 5'h00;
    logic [15:0] pc_in = 16'h0000, index_in = 16'h0000, sp_in = 16'h0000, word_in = 16'h0000;
    logic [7:0] acc_in = 8'h00, new_operand_in = 8'h00;
    wire logic [7:0] data_in, data_out;
    wire logic [15:0] addr_out, sp_out;
    wire logic rw_out, data_oe_out, bus_cycle_out, busy_out, done_out;
    wire logic [3:0] cycle_out, kind_out;
    int bad_count = 0;
    int n_compared = 0;
    int tick = 0;
    logic [31:0] lfsr_r = 32'h0000019D;
    logic [15:0] exp_sp;
    iibs_exp_t exp_q[$];

    iibs_seq u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
        .class_in(class_in), .pc_in(pc_in), .index_in(index_in), .sp_in(sp_in),
        .acc_in(acc_in), .word_in(word_in), .new_operand_in(new_operand_in),
        .data_in(data_in), .addr_out(addr_out), .rw_out(rw_out), .data_oe_out(data_oe_out),
        .data_out(data_out), .bus_cycle_out(bus_cycle_out), .cycle_out(cycle_out),
        .kind_out(kind_out), .busy_out(busy_out), .done_out(done_out), .sp_out(sp_out));
    iibs_mem_model u_mem (.clk_in(clk_in), .addr_in(addr_out), .rw_in(rw_out),
        .cycle_in(bus_cycle_out), .data_out(data_in));

    function automatic logic [7:0] cell_ref(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'hA5;
    endfunction : cell_ref
    // 32 shifts per call so successive words are not plain shifted copies
    function automatic logic [31:0] rnd();
        repeat (32) lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction : rnd
    task automatic put(input logic [15:0] a, input logic wr = 1'b0, input logic [7:0] d = 8'h00);
        exp_q.push_back({a, ~wr, d});
    endtask : put
    // drive a fresh random instruction and build its expected bus walk
    task automatic launch(input logic [4:0] c);
        logic [15:0] ea;
        logic [15:0] xa;
        logic [15:0] ret;
        logic [15:0] sp_t;
        string t;
        {pc_in, index_in} = rnd();
        {sp_in, word_in} = rnd();
        {acc_in, new_operand_in, ea} = rnd();
        class_in = c;
        start_in = 1'b1;
        ea = index_in + {8'h00, cell_ref(pc_in + 16'h0001)};
        xa = {cell_ref(pc_in + 16'h0001), cell_ref(pc_in + 16'h0002)};
        ret = pc_in + 16'h0002;
        sp_t = sp_in;
        t = tail_tab[c];
        exp_q = {};
        put(pc_in);
        put(pc_in + 16'h0001);
        // indexed classes spend cycle 3 on a dummy top read
        if (c <= 5'h08) put(TOP);
        for (int i = 0; i < t.len(); i++) begin
            case (t[i])
                "E": put(ea);
                "F": put(ea + 16'h0001);
                "T": put(TOP);
                "A": put(ea, 1'b1, acc_in);
                "H": put(ea, 1'b1, word_in[15:8]);
                "L": put(ea + 16'h0001, 1'b1, word_in[7:0]);
                "N": put(ea, 1'b1, new_operand_in);
                "S": put(sp_t);
                "U": put(sp_t + 16'h0001);
                "a": put(sp_t, 1'b1, acc_in);
                "x": put(sp_t, 1'b1, index_in[7:0]);
                "y": put(sp_t, 1'b1, index_in[15:8]);
                "r": put(sp_t, 1'b1, ret[7:0]);
                "q": put(sp_t, 1'b1, ret[15:8]);
                "P": put(pc_in + 16'h0002);
                "X": put(xa);
                "M": put(xa, 1'b1, new_operand_in);
                default: ;
            endcase
            // stack writes step down after the byte, stack pulls step up
            if (t[i] inside {"a", "x", "y", "r", "q"}) sp_t = sp_t - 16'h0001;
            if (t[i] == "U") sp_t = sp_t + 16'h0001;
        end
        // stack adjust moves only after reading the old value
        if (c == iibs_pkg::CLS_INH_SP_INC) sp_t = sp_t + 16'h0001;
        if (c == iibs_pkg::CLS_INH_SP_DEC) sp_t = sp_t - 16'h0001;
        exp_sp = sp_t;
    endtask : launch
    // walk expected cycles; hold start into cycle 1 (refused) or chain the next class
    task automatic follow(input bit hold, input bit chain, input logic [4:0] nc);
        iibs_exp_t q[$];
        logic [15:0] sp_e;
        q = exp_q;
        sp_e = exp_sp;
        for (int k = 1; k <= q.size(); k++) begin
            @(negedge clk_in);
            `CHK("addr", q[k-1].a, addr_out)
            `CHK("rw", q[k-1].rw, rw_out)
            `CHK("oe", ~q[k-1].rw, data_oe_out)
            `CHK("wdata", q[k-1].d, data_out)
            `CHK("cycle", 4'(k), cycle_out)
            `CHK("done", k == q.size(), done_out)
            `CHK("busy", 2'b11, {busy_out, bus_cycle_out})
            if (k == 1) `CHK("kind", iibs_pkg::KIND_OPCODE, kind_out)
            if (k == q.size() && chain) launch(nc);
            else start_in = (k == 1) && hold;
        end
        if (!chain) begin
            @(negedge clk_in);
            `CHK("idle", {TOP, 1'b0}, {addr_out, busy_out})
            @(negedge clk_in);
            `CHK("sp", sp_e, sp_out)
        end
    endtask : follow
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial begin
        forever #2 clk_in = ~clk_in;
    end
    // a full run needs well under two thousand cycles
    always @(posedge clk_in) begin
        tick++;
        if (tick == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    // plain pass, pass with a refused start, pass with back-to-back chaining
    initial begin
        repeat (16) @(negedge clk_in);
        sys_rst_in = 1'b0;
        `CHK("reset sp", 16'h0000, sp_out)
        `CHK("reset kind", iibs_pkg::KIND_IGNORED, kind_out)
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 20; c++) begin
                if (c == 0 || r != 2) launch(5'(c));
                follow(r == 1, r == 2 && c < 19, 5'(c + 1));
                $display("pass %0d class %0d finished", r, c);
            end
        end
        // reset in the middle of a call parks the bus at once
        launch(iibs_pkg::CLS_IDX_CALL);
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'b1;
        @(negedge clk_in);
        `CHK("reset mid call", 2'b01, {busy_out, rw_out})
        sys_rst_in = 1'b0;
        launch(iibs_pkg::CLS_INH_PULL_INDEX);
        follow(1'b0, 1'b0, 5'h00);
        $display("reset recovery finished");
        print_verdict();
    end
endmodule : iibs_seq_tb
